// *** src/coef_addr_pkg.sv ***
// Constants and carriers for coefficient memory block addressing
package coef_addr_pkg;
	localparam int NUM_WORDS   = 40;
	localparam int NUM_BLOCKS  = 5;
	localparam int BLOCK_WORDS = 8;
	localparam int CODE_W      = 3;
	localparam int INDEX_W     = 3;
	localparam int ADDR_W      = 6;
	localparam logic [CODE_W-1:0]  BLK_IMPEDANCE = 3'h0;
	localparam logic [CODE_W-1:0]  BLK_HYBRID    = 3'h1;
	localparam logic [CODE_W-1:0]  BLK_TONE      = 3'h2;
	localparam logic [CODE_W-1:0]  BLK_TRANSMIT  = 3'h3;
	localparam logic [CODE_W-1:0]  BLK_RECEIVE   = 3'h4;
	localparam logic [INDEX_W-1:0] INDEX_FIRST   = 3'h7;
	localparam logic [INDEX_W-1:0] INDEX_LAST    = 3'h0;
	localparam logic [INDEX_W-1:0] INDEX_SPLIT   = 3'h4;
	localparam logic [INDEX_W-1:0] TONE0_FREQ_IX = 3'h4;
	localparam logic [INDEX_W-1:0] TONE0_AMPL_IX = 3'h5;
	localparam logic [INDEX_W-1:0] TONE1_FREQ_IX = 3'h6;
	localparam logic [INDEX_W-1:0] TONE1_AMPL_IX = 3'h7;

	typedef enum logic [12:0] {
		GRP_NONE      = 13'h0000,
		GRP_IMPEDANCE = 13'h0001,
		GRP_HYBRID    = 13'h0002,
		GRP_GAIN_ADJ  = 13'h0004,
		GRP_T0_FREQ   = 13'h0008,
		GRP_T0_AMPL   = 13'h0010,
		GRP_T1_FREQ   = 13'h0020,
		GRP_T1_AMPL   = 13'h0040,
		GRP_TX_FREQ   = 13'h0080,
		GRP_TX_GAIN   = 13'h0100,
		GRP_RX_FREQ   = 13'h0200,
		GRP_RX_GAIN   = 13'h0400
	} group_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              last;
		logic              rx_pair;
		group_type         group;
	} word_access_type;
endpackage

// *** src/coef_block_addr.sv ***
// Coefficient memory block address sequencer
`timescale 1ns/1ps
`default_nettype none
// Group decode for one word of the memory
module coef_group_decode (
	input  wire logic [coef_addr_pkg::CODE_W-1:0]  i_block,
	input  wire logic [coef_addr_pkg::INDEX_W-1:0] i_index,
	output var coef_addr_pkg::group_type           o_group
);
	logic upper_half;

	// Gain words sit in the upper half of the transmit and receive blocks
	assign upper_half = i_index >= coef_addr_pkg::INDEX_SPLIT;

	always_comb begin
		o_group = coef_addr_pkg::GRP_NONE;
		unique case (i_block)
			coef_addr_pkg::BLK_IMPEDANCE: begin
				o_group = coef_addr_pkg::GRP_IMPEDANCE;
			end
			coef_addr_pkg::BLK_HYBRID: begin
				o_group = coef_addr_pkg::GRP_HYBRID;
			end
			coef_addr_pkg::BLK_TONE: begin
				unique case (i_index)
					coef_addr_pkg::TONE0_FREQ_IX: begin
						o_group = coef_addr_pkg::GRP_T0_FREQ;
					end
					coef_addr_pkg::TONE0_AMPL_IX: begin
						o_group = coef_addr_pkg::GRP_T0_AMPL;
					end
					coef_addr_pkg::TONE1_FREQ_IX: begin
						o_group = coef_addr_pkg::GRP_T1_FREQ;
					end
					coef_addr_pkg::TONE1_AMPL_IX: begin
						o_group = coef_addr_pkg::GRP_T1_AMPL;
					end
					default: begin
						o_group = coef_addr_pkg::GRP_GAIN_ADJ;
					end
				endcase
			end
			coef_addr_pkg::BLK_TRANSMIT: begin
				if (upper_half) begin
					o_group = coef_addr_pkg::GRP_TX_GAIN;
				end else begin
					o_group = coef_addr_pkg::GRP_TX_FREQ;
				end
			end
			coef_addr_pkg::BLK_RECEIVE: begin
				// Both halves share one walk, so one command loads both
				if (upper_half) begin
					o_group = coef_addr_pkg::GRP_RX_GAIN;
				end else begin
					o_group = coef_addr_pkg::GRP_RX_FREQ;
				end
			end
			default: begin
				o_group = coef_addr_pkg::GRP_NONE;
			end
		endcase
	end
endmodule // coef_group_decode

module coef_block_addr (
	input  wire logic                             i_clk,
	input  wire logic                             i_nrst,
	input  wire logic                             i_cmd_valid,
	input  wire logic [coef_addr_pkg::CODE_W-1:0] i_cmd_block,
	input  wire logic                             i_word_ready,
	output logic                                  o_cmd_ready,
	output logic                                  o_cmd_error,
	output logic                                  o_word_valid,
	output var coef_addr_pkg::word_access_type    o_word
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WALK = 2'b10
	} state_type;

	state_type                         state_r, state_nxt;
	logic [coef_addr_pkg::CODE_W-1:0]  block_r, block_nxt;
	logic [coef_addr_pkg::INDEX_W-1:0] index_r, index_nxt;
	logic                              err_r, err_nxt;
	coef_addr_pkg::word_access_type    word_r, word_nxt;
	coef_addr_pkg::group_type          group_nxt;
	logic                              code_ok;
	logic                              take;
	logic                              step;
	logic                              at_last;

	// Codes above 100 name no block; 40 words fill only five
	assign code_ok = i_cmd_block <= coef_addr_pkg::BLK_RECEIVE;
	assign take    = (state_r == ST_IDLE) && i_cmd_valid;
	assign step    = (state_r == ST_WALK) && i_word_ready;
	assign at_last = index_r == coef_addr_pkg::INDEX_LAST;

	// Walk control
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (take && code_ok) begin
					state_nxt = ST_WALK;
				end
			end
			ST_WALK: begin
				// Commands are ignored until the last word is taken
				if (step && at_last) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Block code and word index
	always_comb begin
		block_nxt = block_r;
		index_nxt = index_r;
		if (take && code_ok) begin
			block_nxt = i_cmd_block;
			index_nxt = coef_addr_pkg::INDEX_FIRST;
		end else if (step && !at_last) begin
			index_nxt = index_r - 3'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			block_r <= coef_addr_pkg::BLK_IMPEDANCE;
			index_r <= coef_addr_pkg::INDEX_LAST;
		end else begin
			block_r <= block_nxt;
			index_r <= index_nxt;
		end
	end

	// Refusal pulse, one cycle per bad offer
	always_comb begin
		err_nxt = take && !code_ok;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			err_r <= 1'b0;
		end else begin
			err_r <= err_nxt;
		end
	end

	// Word fields, built from next values so the register lines up
	coef_group_decode u_group (
		.i_block (block_nxt),
		.i_index (index_nxt),
		.o_group (group_nxt)
	);

	always_comb begin
		word_nxt.addr    = {block_nxt, index_nxt};
		word_nxt.last    = index_nxt == coef_addr_pkg::INDEX_LAST;
		word_nxt.rx_pair = block_nxt == coef_addr_pkg::BLK_RECEIVE;
		word_nxt.group   = group_nxt;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			word_r.addr    <= {coef_addr_pkg::BLK_IMPEDANCE,
				coef_addr_pkg::INDEX_LAST};
			word_r.last    <= 1'b1;
			word_r.rx_pair <= 1'b0;
			word_r.group   <= coef_addr_pkg::GRP_IMPEDANCE;
		end else begin
			word_r <= word_nxt;
		end
	end

	assign o_cmd_ready  = state_r == ST_IDLE;
	assign o_cmd_error  = err_r;
	assign o_word_valid = state_r == ST_WALK;
	// Registered, so no glitch reaches the memory address lines
	assign o_word       = word_r;
endmodule // coef_block_addr
`default_nettype wire

// *** sim/coef_block_addr_sva.sv ***
// Checker for the coefficient block sequencer
`timescale 1ns/1ps
`default_nettype none
module coef_block_addr_sva (
	input wire logic                             i_clk,
	input wire logic                             i_nrst,
	input wire logic                             i_cmd_valid,
	input wire logic [coef_addr_pkg::CODE_W-1:0] i_cmd_block,
	input wire logic                             i_word_ready,
	input wire logic                             o_cmd_ready,
	input wire logic                             o_cmd_error,
	input wire logic                             o_word_valid,
	input wire coef_addr_pkg::word_access_type   o_word
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	logic take;
	assign take = o_cmd_ready && i_cmd_valid;
	start_word_a: assert property (take && i_cmd_block <= 3'h4 |=> o_word_valid
		&& o_word.addr == {$past(i_cmd_block), 3'h7}) else $error("bad start");
	step_down_a: assert property (o_word_valid && i_word_ready && !o_word.last
		|=> o_word.addr == $past(o_word.addr) - 6'h01) else $error("bad step");
	walk_end_a: assert property (o_word_valid && i_word_ready && o_word.last
		|=> !o_word_valid && o_cmd_ready) else $error("walk not ended");
	hold_word_a: assert property (o_word_valid && !i_word_ready
		|=> o_word_valid && $stable(o_word)) else $error("word dropped");
	rx_pair_a: assert property (o_word_valid
		|-> o_word.rx_pair == (o_word.addr[5:3] == 3'h4)) else $error("bad pair");
	tone_map_a: assert property (o_word_valid && o_word.addr == 6'h14
		|-> o_word.group == coef_addr_pkg::GRP_T0_FREQ) else $error("bad tone");
	bad_code_a: assert property (take && i_cmd_block > 3'h4
		|=> o_cmd_error && !o_word_valid) else $error("code not refused");
	last_flag_a: assert property (o_word_valid
		|-> o_word.last == (o_word.addr[2:0] == 3'h0)) else $error("bad last");
	imp_group_a: assert property (o_word_valid && o_word.addr[5:3] == 3'h0
		|-> o_word.group == coef_addr_pkg::GRP_IMPEDANCE)
		else $error("bad impedance group");
	rx_split_a: assert property (o_word_valid && o_word.addr[5:3] == 3'h4
		|-> o_word.group == (o_word.addr[2] ? coef_addr_pkg::GRP_RX_GAIN
		: coef_addr_pkg::GRP_RX_FREQ)) else $error("bad receive split");
endmodule // coef_block_addr_sva
`default_nettype wire

// *** sim/word_sink.sv ***
// Word consumer model, stalls every other cycle when slow
`timescale 1ns/1ps
`default_nettype none
module word_sink (
	input  wire logic i_clk,
	input  wire logic i_slow,
	output logic      o_word_ready
);
	logic tick_r = 1'b0;
	always @(negedge i_clk) tick_r <= ~tick_r;
	assign o_word_ready = ~i_slow | tick_r;
endmodule // word_sink
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the coefficient block sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin samples_checked++; if ((a) !== (e)) begin \
	mismatches++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
	logic i_clk = 0, i_nrst = 0, i_cmd_valid = 0, slow = 0;
	logic i_word_ready, o_cmd_ready, o_cmd_error, o_word_valid;
	logic [2:0] i_cmd_block = 3'h0;
	coef_addr_pkg::word_access_type o_word;
	int mismatches = 0, samples_checked = 0;
	always #5 i_clk = ~i_clk;
	coef_block_addr dut (.*);
	word_sink sink (.i_clk(i_clk), .i_slow(slow), .o_word_ready(i_word_ready));
	task issue(input logic [2:0] b);
		@(negedge i_clk);
		i_cmd_valid = 1'b1;
		i_cmd_block = b;
		@(negedge i_clk);
		i_cmd_valid = 1'b0;
	endtask
	function automatic coef_addr_pkg::group_type exp_group(
		input logic [2:0] b, input logic [2:0] ix);
		case (b)
			3'h0: return coef_addr_pkg::GRP_IMPEDANCE;
			3'h1: return coef_addr_pkg::GRP_HYBRID;
			3'h2: case (ix)
				3'h4: return coef_addr_pkg::GRP_T0_FREQ;
				3'h5: return coef_addr_pkg::GRP_T0_AMPL;
				3'h6: return coef_addr_pkg::GRP_T1_FREQ;
				3'h7: return coef_addr_pkg::GRP_T1_AMPL;
				default: return coef_addr_pkg::GRP_GAIN_ADJ;
			endcase
			3'h3: return ix[2] ? coef_addr_pkg::GRP_TX_GAIN
				: coef_addr_pkg::GRP_TX_FREQ;
			default: return ix[2] ? coef_addr_pkg::GRP_RX_GAIN
				: coef_addr_pkg::GRP_RX_FREQ;
		endcase
	endfunction
	task walk(input logic [2:0] b);
		logic [2:0] ix;
		int n;
		ix = 3'h7;
		n = 0;
		issue(b);
		repeat (40) begin
			#1;
			if (o_word_valid && i_word_ready) begin
				`CHK("addr", {b, ix}, o_word.addr)
				`CHK("pair", b == 3'h4, o_word.rx_pair)
				`CHK("last", ix == 3'h0, o_word.last)
				if (b == 3'h2 && ix == 3'h5)
					`CHK("tone", coef_addr_pkg::GRP_T0_AMPL, o_word.group)
				`CHK("group", exp_group(b, ix), o_word.group)
				ix--;
				n++;
			end
			@(negedge i_clk);
		end
		`CHK("count", 3'h7, ix)
		`CHK("words", 8, n)
		`CHK("ready", 1'b1, o_cmd_ready)
		$display("walk %h done", b);
	endtask
	task refuse;
		issue(3'h5);
		`CHK("err", 1'b1, o_cmd_error)
		`CHK("idle", 1'b0, o_word_valid)
		$display("refuse done");
	endtask
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge i_clk);
		i_nrst = 1'b1;
		for (int b = 0; b < 5; b++) walk(3'(b));
		slow = 1'b1;
		walk(3'h2);
		refuse();
		summarize();
	end
	initial begin
		#20000;
		mismatches++;
		summarize();
	end
endmodule // testbench
bind coef_block_addr coef_block_addr_sva chk (.*);
`default_nettype wire
